// ### asc_consts.vh
// Constants for the converter sequencing control block
// Overview of operation
// RQ1: Reference from core supply only for code 01
// RQ2: Software enables reference pin function first
// RQ3: Keep reference pin off with supply reference; pin-function bit alone drives the pin, software guards it
// RQ4: Analog enable bit takes pin from port
// RQ5: Pull-high removed while pin is analog
// RQ6: Analog enable overrides port direction
// RQ7: External sources route channels 0 to 7
// RQ8: Channel code 1xxx leaves input floating
// RQ9: Source 001 routes bandgap; channel must be 1xxx
// RQ10: Sources 010, 011, 100 ground the input
// RQ11: Start bit low-high-low starts one conversion
// RQ12: Busy set on start, cleared at completion
// RQ13: Completion sets request flag, raises interrupt
// RQ14: Conversion clock divides by 1 to 128
// RQ15: Software keeps clock period 0.5 to 10 us
// RQ16: Analog powered only while power bit high
// RQ17: Software clears power bit when idle
// RQ18: Sixteen periods: four sample, twelve convert
// RQ19: Format bit selects result byte split
// RQ20: Power off keeps result bytes unchanged
// RQ21: Busy flag ignores software writes
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH
// Register byte addresses on the bus
`define ASC_ADDR_CTRL0 12'h000
`define ASC_ADDR_CTRL1 12'h004
`define ASC_ADDR_PINEN 12'h008
`define ASC_ADDR_PINFN 12'h00C
`define ASC_ADDR_RESH 12'h010
`define ASC_ADDR_RESL 12'h014
`define ASC_ADDR_IRQ 12'h018
`define ASC_ADDR_W 12
// Control register 0 fields
`define ASC_C0_START 7
`define ASC_C0_BUSY 6
`define ASC_C0_PWR 5
`define ASC_C0_FMT 4
`define ASC_C0_CH_MSB 3
`define ASC_C0_CH_LO 0
// Control register 1 fields
`define ASC_C1_SRC_HI 7
`define ASC_C1_SRC_LO 5
`define ASC_C1_REF_HI 4
`define ASC_C1_REF_LO 3
`define ASC_C1_DIV_HI 2
`define ASC_C1_DIV_LO 0
// Pin function register and interrupt register bits
`define ASC_PF_REFPIN 0
`define ASC_IRQ_FLAG 0
`define ASC_IRQ_EN 1
// Codes
`define ASC_REF_CORE 2'b01
`define ASC_SRC_BANDGAP 3'b001
`define ASC_SRC_GND_A 3'b010
`define ASC_SRC_GND_B 3'b011
`define ASC_SRC_GND_C 3'b100
// Route select encodings towards the analog core
`define ASC_ROUTE_FLOAT 2'b00
`define ASC_ROUTE_EXT 2'b01
`define ASC_ROUTE_BG 2'b10
`define ASC_ROUTE_GND 2'b11
// Conversion timing in conversion clock periods
`define ASC_SAMPLE_TICKS 5'd4
`define ASC_TOTAL_TICKS 5'd16
`define ASC_HTRANS_NONSEQ 2'b10
`endif

// ### asc_clk_div.v
// Conversion clock tick generator from the system clock
`timescale 1ns/1ps
module asc_clk_div
(
	input wire i_clk,
	input wire i_reset,
	input wire i_run,
	input wire [2:0] i_div_sel,
	output reg o_tick
);
	reg [6:0] cnt_reg;
	wire [6:0] limit;

	// Divide by two to the power of the select code
	assign limit = (7'h01 << i_div_sel) - 7'h01; // RQ14

	////////////////////////////////////////////////////////////////////////
	// Counter restarts while idle so each conversion begins phase aligned
	always @(posedge i_clk)
	begin
		if (i_reset || !i_run)
		begin
			cnt_reg <= 7'h00;
			o_tick <= 1'b0;
		end
		else if (cnt_reg >= limit)
		begin
			cnt_reg <= 7'h00;
			o_tick <= 1'b1; // RQ14
		end
		else
		begin
			cnt_reg <= cnt_reg + 7'h01;
			o_tick <= 1'b0;
		end
	end
endmodule // asc_clk_div

// ### asc_in_sync.v
// Two-flop synchroniser for the analog core result inputs
`timescale 1ns/1ps
module asc_in_sync
(
	input wire i_clk,
	input wire i_reset,
	input wire [12:0] i_async,
	output reg [12:0] o_sync
);
	reg [12:0] meta_reg;

	// First stage is read by the second stage only
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			meta_reg <= 13'h0000;
			o_sync <= 13'h0000;
		end
		else
		begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule // asc_in_sync

// ### asc_top.v
// Converter sequencing control with AHB-Lite register slave
`timescale 1ns/1ps
`include "asc_consts.vh"
module asc_top
(
	input wire i_clk,
	input wire i_reset,
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output reg [31:0] o_hrdata,
	output reg o_hreadyout,
	output reg o_hresp,
	input wire [7:0] i_port_pullup_en,
	input wire [7:0] i_port_dir_out,
	input wire [7:0] i_port_alt_en,
	input wire [11:0] i_core_data,
	input wire i_core_data_valid,
	output reg o_ref_from_core,
	output reg o_ref_pin_enable,
	output reg [1:0] o_route_sel,
	output reg [2:0] o_ext_channel,
	output reg [7:0] o_analog_pin_enable,
	output reg [7:0] o_pullup_active,
	output reg [7:0] o_port_dir_out,
	output reg [7:0] o_port_alt_en,
	output reg o_core_power,
	output reg o_core_sample,
	output reg o_core_convert,
	output reg o_core_tick,
	output reg o_irq
);
	// Sample-then-convert sequencer states
	localparam ST_IDLE = 3'b001;
	localparam ST_SAMPLE = 3'b010;
	localparam ST_CONVERT = 3'b100;

	reg [7:0] ctrl0_reg;
	reg [7:0] ctrl1_reg;
	reg [7:0] pin_en_reg;
	reg [7:0] pin_fn_reg;
	reg [7:0] res_hi_reg;
	reg [7:0] res_lo_reg;
	reg irq_flag_reg;
	reg irq_en_reg;
	reg busy_reg;
	reg start_armed_reg;
	reg [2:0] state_reg;
	reg [4:0] tick_cnt_reg;
	reg [11:0] capture_reg;
	reg wr_pend_reg;
	reg rd_pend_reg;
	reg [`ASC_ADDR_W-1:0] addr_reg;
	wire [12:0] core_sync;
	wire conv_tick;
	wire done_pulse;
	wire [2:0] src_sel;
	wire src_external;
	wire src_ground;
	wire new_start;

	////////////////////////////////////////////////////////////////////////
	// Result bus from the analog core arrives asynchronously
	asc_in_sync u_sync
	(
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async({i_core_data_valid, i_core_data}),
		.o_sync(core_sync)
	);

	// Conversion clock only runs while a conversion is in progress
	asc_clk_div u_div
	(
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_run(busy_reg),
		.i_div_sel(ctrl1_reg[`ASC_C1_DIV_HI:`ASC_C1_DIV_LO]),
		.o_tick(conv_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus address phase capture; transfers are zero wait state
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= {`ASC_ADDR_W{1'b0}};
		end
		else if (i_hready)
		begin
			wr_pend_reg <= i_hsel && i_htrans[1] && i_hwrite;
			rd_pend_reg <= i_hsel && i_htrans[1] && !i_hwrite;
			addr_reg <= i_haddr[`ASC_ADDR_W-1:0];
		end
	end

	// Always ready, always OKAY
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
		else
		begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Start is armed by a high write and fires on the later low write
	assign new_start = wr_pend_reg && (addr_reg == `ASC_ADDR_CTRL0)
		&& start_armed_reg && !i_hwdata[`ASC_C0_START]; // RQ11
	assign done_pulse = (state_reg == ST_CONVERT) && conv_tick
		&& (tick_cnt_reg == `ASC_TOTAL_TICKS - 5'd1); // RQ18

	// Software-written registers
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			ctrl0_reg <= 8'h00;
			ctrl1_reg <= 8'h00;
			pin_en_reg <= 8'h00;
			pin_fn_reg <= 8'h00;
			irq_en_reg <= 1'b0;
			start_armed_reg <= 1'b0;
		end
		else if (wr_pend_reg)
		begin
			case (addr_reg)
				`ASC_ADDR_CTRL0:
				begin
					// Busy bit position holds no software state
					ctrl0_reg <= i_hwdata[7:0] & ~(8'h01 << `ASC_C0_BUSY); // RQ21
					start_armed_reg <= i_hwdata[`ASC_C0_START]; // RQ11
				end
				`ASC_ADDR_CTRL1: ctrl1_reg <= i_hwdata[7:0];
				`ASC_ADDR_PINEN: pin_en_reg <= i_hwdata[7:0];
				`ASC_ADDR_PINFN: pin_fn_reg <= i_hwdata[7:0];
				`ASC_ADDR_IRQ: irq_en_reg <= i_hwdata[`ASC_IRQ_EN];
				default: ctrl0_reg <= ctrl0_reg;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencer: four sample periods then twelve convert periods
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			state_reg <= ST_IDLE;
			tick_cnt_reg <= 5'd0;
			busy_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					tick_cnt_reg <= 5'd0;
					// Conversion needs the analog core powered
					if (new_start && ctrl0_reg[`ASC_C0_PWR])
					begin
						state_reg <= ST_SAMPLE;
						busy_reg <= 1'b1; // RQ12
					end
				end
				ST_SAMPLE:
				begin
					if (!ctrl0_reg[`ASC_C0_PWR])
					begin
						state_reg <= ST_IDLE;
						busy_reg <= 1'b0;
					end
					else if (conv_tick)
					begin
						tick_cnt_reg <= tick_cnt_reg + 5'd1;
						if (tick_cnt_reg == `ASC_SAMPLE_TICKS - 5'd1)
							state_reg <= ST_CONVERT; // RQ18
					end
				end
				ST_CONVERT:
				begin
					if (!ctrl0_reg[`ASC_C0_PWR])
					begin
						state_reg <= ST_IDLE;
						busy_reg <= 1'b0;
					end
					else if (done_pulse)
					begin
						state_reg <= ST_IDLE;
						busy_reg <= 1'b0; // RQ12
					end
					else if (conv_tick)
						tick_cnt_reg <= tick_cnt_reg + 5'd1;
				end
				default:
				begin
					state_reg <= ST_IDLE;
					busy_reg <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result capture; powered-off core leaves the bytes untouched
	always @(posedge i_clk)
	begin
		if (i_reset)
			capture_reg <= 12'h000;
		else if (core_sync[12] && busy_reg)
			capture_reg <= core_sync[11:0];
	end

	// Result bytes load only at completion
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			res_hi_reg <= 8'h00;
			res_lo_reg <= 8'h00;
		end
		else if (done_pulse) // RQ20
		begin
			if (ctrl0_reg[`ASC_C0_FMT])
			begin
				res_hi_reg <= {4'h0, capture_reg[11:8]}; // RQ19
				res_lo_reg <= capture_reg[7:0];
			end
			else
			begin
				res_hi_reg <= capture_reg[11:4]; // RQ19
				res_lo_reg <= {capture_reg[3:0], 4'h0};
			end
		end
	end

	// Request flag: completion wins over a clearing write
	always @(posedge i_clk)
	begin
		if (i_reset)
			irq_flag_reg <= 1'b0;
		else if (done_pulse)
			irq_flag_reg <= 1'b1; // RQ13
		else if (wr_pend_reg && addr_reg == `ASC_ADDR_IRQ && i_hwdata[`ASC_IRQ_FLAG])
			irq_flag_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read zero
	always @(posedge i_clk)
	begin
		if (i_reset)
			o_hrdata <= 32'h0000_0000;
		else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite)
		begin
			case (i_haddr[`ASC_ADDR_W-1:0])
				`ASC_ADDR_CTRL0: o_hrdata <= {24'h00_0000, ctrl0_reg[`ASC_C0_START],
					busy_reg, ctrl0_reg[`ASC_C0_PWR:`ASC_C0_CH_LO]};
				`ASC_ADDR_CTRL1: o_hrdata <= {24'h00_0000, ctrl1_reg};
				`ASC_ADDR_PINEN: o_hrdata <= {24'h00_0000, pin_en_reg};
				`ASC_ADDR_PINFN: o_hrdata <= {24'h00_0000, pin_fn_reg};
				`ASC_ADDR_RESH: o_hrdata <= {24'h00_0000, res_hi_reg};
				`ASC_ADDR_RESL: o_hrdata <= {24'h00_0000, res_lo_reg};
				`ASC_ADDR_IRQ: o_hrdata <= {30'h0000_0000, irq_en_reg, irq_flag_reg};
				default: o_hrdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input routing decode
	assign src_sel = ctrl1_reg[`ASC_C1_SRC_HI:`ASC_C1_SRC_LO];
	assign src_ground = (src_sel == `ASC_SRC_GND_A) || (src_sel == `ASC_SRC_GND_B)
		|| (src_sel == `ASC_SRC_GND_C);
	assign src_external = (src_sel != `ASC_SRC_BANDGAP) && !src_ground;

	// Registered drives to analog core and pad ring
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_ref_from_core <= 1'b0;
			o_ref_pin_enable <= 1'b0;
			o_route_sel <= `ASC_ROUTE_FLOAT;
			o_ext_channel <= 3'b000;
			o_analog_pin_enable <= 8'h00;
			o_pullup_active <= 8'h00;
			o_port_dir_out <= 8'h00;
			o_port_alt_en <= 8'h00;
			o_core_power <= 1'b0;
			o_core_sample <= 1'b0;
			o_core_convert <= 1'b0;
			o_core_tick <= 1'b0;
			o_irq <= 1'b0;
		end
		else
		begin
			o_ref_from_core <= (ctrl1_reg[`ASC_C1_REF_HI:`ASC_C1_REF_LO] == `ASC_REF_CORE); // RQ1
			// Pin-function bit alone owns the reference pin; software guards the clash
			o_ref_pin_enable <= pin_fn_reg[`ASC_PF_REFPIN]; // RQ2 RQ3
			if (src_ground)
				o_route_sel <= `ASC_ROUTE_GND; // RQ10
			else if (!src_external)
				o_route_sel <= `ASC_ROUTE_BG; // RQ9
			else if (ctrl0_reg[`ASC_C0_CH_MSB])
				o_route_sel <= `ASC_ROUTE_FLOAT; // RQ8
			else
				o_route_sel <= `ASC_ROUTE_EXT; // RQ7
			o_ext_channel <= ctrl0_reg[`ASC_C0_CH_MSB-1:`ASC_C0_CH_LO]; // RQ7
			o_analog_pin_enable <= pin_en_reg; // RQ4
			o_pullup_active <= i_port_pullup_en & ~pin_en_reg; // RQ5
			o_port_dir_out <= i_port_dir_out & ~pin_en_reg; // RQ6
			o_port_alt_en <= i_port_alt_en & ~pin_en_reg; // RQ4
			o_core_power <= ctrl0_reg[`ASC_C0_PWR]; // RQ16
			o_core_sample <= (state_reg == ST_SAMPLE);
			o_core_convert <= (state_reg == ST_CONVERT);
			// Divider can tick once more as busy drops; keep that off the core
			o_core_tick <= conv_tick && busy_reg; // RQ14
			o_irq <= irq_flag_reg && irq_en_reg; // RQ13
		end
	end
endmodule // asc_top

// ### asc_checker.sv
// Port-level assertions for the converter sequencing control
`timescale 1ns/1ps
module asc_checker
(
	input wire i_clk,
	input wire i_reset,
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire i_hready,
	input wire [31:0] o_hrdata,
	input wire [7:0] i_port_pullup_en,
	input wire [7:0] i_port_dir_out,
	input wire [7:0] o_analog_pin_enable,
	input wire [7:0] o_pullup_active,
	input wire [7:0] o_port_dir_out,
	input wire o_core_power,
	input wire o_core_sample,
	input wire o_core_convert
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);
	////////////////////////////////////////
	// Masks are judged only while the enables hold still, as both lag one clock
	sequence s_pins_quiet;
		!$past(i_reset) && $stable(o_analog_pin_enable);
	endsequence
	// A power drop is the only excuse for a phase ending early
	sequence s_sample_kept;
		(o_core_sample || !o_core_power) [*4];
	endsequence
	sequence s_convert_kept;
		(o_core_convert || !o_core_power) [*8];
	endsequence
	pull_mask_a:
	assert property (s_pins_quiet |-> o_pullup_active ==
		($past(i_port_pullup_en) & ~o_analog_pin_enable)) else $error("pull-up left on");
	dir_mask_a:
	assert property (s_pins_quiet |-> o_port_dir_out ==
		($past(i_port_dir_out) & ~o_analog_pin_enable)) else $error("direction not overridden");
	sample_len_a:
	assert property ($rose(o_core_sample) |-> s_sample_kept) else $error("sample phase short");
	convert_len_a:
	assert property ($rose(o_core_convert) |-> s_convert_kept) else $error("convert phase short");
	phase_order_a:
	assert property ($rose(o_core_convert) |-> $past(o_core_sample)) else $error("convert without sample");
	phase_excl_a:
	assert property (!(o_core_sample && o_core_convert)) else $error("both phases active");
	power_gate_a:
	assert property ((o_core_sample || o_core_convert) |-> $past(o_core_power))
		else $error("sequencer runs unpowered");
	unmap_read_a:
	assert property ((i_hsel && i_hready && i_htrans == 2'b10 && !i_hwrite &&
		i_haddr > 32'h0000_0018) |=> o_hrdata == 32'h0000_0000) else $error("unmapped read not zero");
endmodule // asc_checker

bind asc_top asc_checker asc_checker_inst (.i_clk(i_clk), .i_reset(i_reset), .i_hsel(i_hsel),
	.i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
	.o_hrdata(o_hrdata), .i_port_pullup_en(i_port_pullup_en), .i_port_dir_out(i_port_dir_out),
	.o_analog_pin_enable(o_analog_pin_enable), .o_pullup_active(o_pullup_active),
	.o_port_dir_out(o_port_dir_out), .o_core_power(o_core_power), .o_core_sample(o_core_sample),
	.o_core_convert(o_core_convert));

// ### tb_top.sv
// Self-checking bench for the converter sequencing control
`timescale 1ns/1ps
`include "asc_consts.vh"
module tb_top;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, vld = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
	logic [1:0] htrans = 2'h0;
	logic [7:0] pu = 8'h00, dir = 8'h00, alt = 8'h00, e, b;
	logic [11:0] cdat = 12'h000;
	wire [31:0] hrdata;
	wire hready, hresp, ref_core, ref_pin, pwr, samp, conv, tick, irq;
	wire [1:0] route;
	wire [2:0] ech;
	wire [7:0] ape, pua, pdo, pae;
	int mismatches = 0, check_count = 0, act = 0, tk = 0, n, d;
	// Free-running system clock
	initial
	begin
		forever #5 i_clk = ~i_clk;
	end
	asc_top asc_top_inst (.i_clk(i_clk), .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_port_pullup_en(pu), .i_port_dir_out(dir), .i_port_alt_en(alt), .i_core_data(cdat),
		.i_core_data_valid(vld), .o_ref_from_core(ref_core), .o_ref_pin_enable(ref_pin),
		.o_route_sel(route), .o_ext_channel(ech), .o_analog_pin_enable(ape),
		.o_pullup_active(pua), .o_port_dir_out(pdo), .o_port_alt_en(pae), .o_core_power(pwr),
		.o_core_sample(samp), .o_core_convert(conv), .o_core_tick(tick), .o_irq(irq));
	// Cycles the sequencer spends in its phases, and conversion clock ticks
	always @(posedge i_clk)
	begin
		if (samp || conv)
			act <= act + 1;
		if (tick)
			tk <= tk + 1;
	end
	////////////////////////////////////////
	task stop_test;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bounded wait for hready; a stuck bus ends the run
	task wait_rdy;
		n = 0;
		do @(posedge i_clk); while (hready !== 1'b1 && ++n < 50);
		if (hready !== 1'b1)
		begin
			mismatches++;
			stop_test;
		end
	endtask
	task bus(input [11:0] a, input w, input [7:0] wd);
		@(posedge i_clk);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		htrans <= `ASC_HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, wd};
		wait_rdy;
		rd = hrdata;
	endtask
	task settle;
		repeat (2) @(posedge i_clk);
	endtask
	function automatic logic [1:0] exp_route(input [2:0] s, input [3:0] c);
		if (s == 3'h1)
			return `ASC_ROUTE_BG;
		if (s >= 3'h2 && s <= 3'h4)
			return `ASC_ROUTE_GND;
		return c[3] ? `ASC_ROUTE_FLOAT : `ASC_ROUTE_EXT;
	endfunction
	////////////////////////////////////////
	initial
	begin
		void'($urandom(50));
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		// Reset values, then one unmapped word that must read zero
		for (int a = 0; a <= 28; a += 4)
		begin
			bus(a[11:0], 1'b0, 8'h00);
			chk(rd, 32'h0000_0000);
		end
		bus(`ASC_ADDR_CTRL0, 1'b1, 8'h49);
		bus(`ASC_ADDR_CTRL0, 1'b0, 8'h00);
		chk(rd, 32'h0000_0009);
		chk(32'(hresp), 32'h0000_0000);
		// Reference choice; the pin function stays off with the core supply
		for (int r = 0; r < 4; r++)
		begin
			bus(`ASC_ADDR_CTRL1, 1'b1, {3'h0, r[1:0], 3'h0});
			bus(`ASC_ADDR_PINFN, 1'b1, {7'h00, r != 1});
			settle;
			chk(32'(ref_core), 32'(r == 1));
			chk(32'(ref_pin), 32'(r != 1));
		end
		// Every source code against a missing channel, and all but bandgap code 001 against an existing one
		for (int s = 0; s < 8; s++)
			for (int c = 5; c <= 12; c += 7)
				if (s != 1 || c == 12)
				begin
					bus(`ASC_ADDR_CTRL1, 1'b1, {s[2:0], 5'h00});
					bus(`ASC_ADDR_CTRL0, 1'b1, {4'h0, c[3:0]});
					settle;
					chk(32'(route), 32'(exp_route(s[2:0], c[3:0])));
					chk(32'(ech), 32'(c[2:0]));
				end
		repeat (4)
		begin
			e = 8'($urandom);
			pu <= 8'($urandom);
			dir <= 8'($urandom);
			alt <= 8'($urandom);
			bus(`ASC_ADDR_PINEN, 1'b1, e);
			settle;
			chk(32'(ape), 32'(e));
			chk(32'(pua), 32'(pu & ~e));
			chk(32'(pdo), 32'(dir & ~e));
			chk(32'(pae), 32'(alt & ~e));
		end
		// Conversions at two dividers, one per result format
		for (int k = 0; k < 2; k++)
		begin
			// Divide by 64 or 128 keeps the period between 0.5 and 10 us at 100 MHz
			d = 6 + k;
			b = 8'h21 | 8'(k << 4);
			bus(`ASC_ADDR_IRQ, 1'b1, 8'h02);
			bus(`ASC_ADDR_CTRL1, 1'b1, d[7:0]);
			bus(`ASC_ADDR_PINEN, 1'b1, 8'h02);
			bus(`ASC_ADDR_CTRL0, 1'b1, b);
			repeat (10) @(posedge i_clk);
			cdat <= 12'($urandom);
			vld <= 1'b1;
			settle;
			act = 0;
			tk = 0;
			bus(`ASC_ADDR_CTRL0, 1'b1, b | 8'h80);
			bus(`ASC_ADDR_CTRL0, 1'b1, b);
			bus(`ASC_ADDR_CTRL0, 1'b0, 8'h00);
			chk(rd, 32'(b | 8'h40));
			for (int p = 0; p < 1000 && rd[6]; p++)
				bus(`ASC_ADDR_CTRL0, 1'b0, 8'h00);
			chk(32'(rd[6]), 32'h0000_0000);
			settle;
			chk(32'(act >= (16 << d) && act <= (17 << d) + 2), 32'h0000_0001);
			chk(32'(tk), 32'h0000_0010);
			bus(`ASC_ADDR_RESL, 1'b0, 8'h00);
			chk(rd, 32'(k ? cdat[7:0] : {cdat[3:0], 4'h0}));
			bus(`ASC_ADDR_IRQ, 1'b0, 8'h00);
			chk(rd, 32'h0000_0003);
			chk(32'(irq), 32'h0000_0001);
			bus(`ASC_ADDR_IRQ, 1'b1, 8'h03);
			settle;
			chk(32'(irq), 32'h0000_0000);
			bus(`ASC_ADDR_CTRL0, 1'b1, b & 8'hDF);
			settle;
			chk(32'(pwr), 32'h0000_0000);
			bus(`ASC_ADDR_RESH, 1'b0, 8'h00);
			chk(rd, 32'(cdat >> (k ? 8 : 4)));
			// Valid drops before the core data may change again
			vld <= 1'b0;
		end
		stop_test;
	end
endmodule // tb_top
